// ==== include/serial_pkg.sv ====
package serial_pkg;

   // ***************************************************
   // character format
   // ***************************************************
   localparam int        DATA_W    = 8;
   localparam logic [2:0] LAST_IDX = 3'h7;
   localparam logic [3:0] OVS_LAST = 4'hf;
   localparam logic [3:0] OVS_HALF = 4'h7;

   // ***************************************************
   // apb register map
   // ***************************************************
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_STAT  = 8'h04;
   localparam logic [7:0] OFS_TXD   = 8'h08;
   localparam logic [7:0] OFS_RXD   = 8'h0c;
   localparam logic [7:0] OFS_BAUD  = 8'h10;

   localparam int C_TX_ON      = 0;
   localparam int C_RX_ON      = 1;
   localparam int C_PARITY_ON  = 2;
   localparam int C_PARITY_ODD = 3;
   localparam int C_STOP2      = 4;
   localparam int C_FLOW_GATE  = 5;
   localparam int C_MULTIDROP  = 6;
   localparam int C_ADDR_FLAG  = 7;

   localparam int S_HOLD_EMPTY = 0;
   localparam int S_TX_BUSY    = 1;
   localparam int S_RX_AVAIL   = 2;
   localparam int S_PERR       = 3;
   localparam int S_FERR       = 4;
   localparam int S_OVERRUN    = 5;
   localparam int S_BRK        = 6;
   localparam int S_RX_NINTH   = 7;

   localparam logic [7:0]  CTRL_RESET = 8'h00;
   localparam logic [15:0] BAUD_RESET = 16'h0001;

   // ***************************************************
   // state machines
   // ***************************************************
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_NINTH = 3'b011,
      TX_STOP1 = 3'b100,
      TX_STOP2 = 3'b101
   } tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_NINTH = 3'b011,
      RX_STOP  = 3'b100
   } rx_state_t;

   // parity over the data bits only; even gives xor of data
   function automatic logic par_bit(input logic [7:0] d, input logic odd);
      return (^d) ^ odd;
   endfunction : par_bit

endpackage : serial_pkg

// ==== include/serial_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
   logic dev_txd;
   logic dev_de;
   logic far_txd;
   logic cts_n;

   modport device (output dev_txd, output dev_de, input far_txd, input cts_n);
   modport far    (input dev_txd, input dev_de, output far_txd, output cts_n);
endinterface : serial_link_if
`default_nettype wire

// ==== src/char_rx.sv ====
`timescale 1ns/10ps
`default_nettype none
module char_rx (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       tick_i,
   input  wire logic       en_i,
   input  wire logic       rxd_i,
   input  wire logic       ninth_on_i,
   input  wire logic       parity_chk_i,
   input  wire logic       odd_i,
   output logic            done_o,
   output logic [7:0]      data_o,
   output logic            ninth_o,
   output logic            perr_o,
   output logic            ferr_o,
   output logic            brk_o
);
   serial_pkg::rx_state_t state;
   logic       s1, s2, s3, line, line_q;
   logic [3:0] cnt;
   logic [2:0] idx;
   logic [7:0] sh;
   logic       nb;

   wire fall    = line_q & ~line;
   wire at_half = tick_i & (cnt == serial_pkg::OVS_HALF);
   wire at_end  = tick_i & (cnt == serial_pkg::OVS_LAST);

   // ***************************************************
   // pin synchroniser, change taken once stages agree
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1     <= 1'b1;
         s2     <= 1'b1;
         s3     <= 1'b1;
         line   <= 1'b1;
         line_q <= 1'b1;
      end else begin
         s1     <= rxd_i;
         s2     <= s1;
         s3     <= s2;
         line_q <= line;
         if (s2 == s3) begin
            line <= s3;
         end
      end
   end

   // ***************************************************
   // character sampling at bit centre
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state  <= serial_pkg::RX_IDLE;
         cnt    <= 4'h0;
         idx    <= 3'h0;
         sh     <= 8'h00;
         nb     <= 1'b0;
         done_o <= 1'b0;
         data_o <= 8'h00;
         ninth_o <= 1'b0;
         perr_o <= 1'b0;
         ferr_o <= 1'b0;
         brk_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (tick_i) begin
            cnt <= cnt + 4'h1;
         end
         case (state)
            serial_pkg::RX_IDLE: begin
               cnt <= 4'h0;
               nb  <= 1'b0;
               if (en_i && fall) begin
                  state <= serial_pkg::RX_START;
               end
            end
            serial_pkg::RX_START: begin
               if (at_half) begin
                  cnt   <= 4'h0;
                  idx   <= 3'h0;
                  state <= line ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
               end
            end
            serial_pkg::RX_DATA: begin
               if (at_end) begin
                  sh  <= {line, sh[7:1]};
                  idx <= idx + 3'h1;
                  if (idx == serial_pkg::LAST_IDX) begin
                     state <= ninth_on_i ? serial_pkg::RX_NINTH : serial_pkg::RX_STOP;
                  end
               end
            end
            serial_pkg::RX_NINTH: begin
               if (at_end) begin
                  nb    <= line;
                  state <= serial_pkg::RX_STOP;
               end
            end
            serial_pkg::RX_STOP: begin
               if (at_end) begin
                  done_o  <= 1'b1;
                  data_o  <= sh;
                  ninth_o <= nb;
                  ferr_o  <= ~line;
                  perr_o  <= parity_chk_i & (nb != serial_pkg::par_bit(sh, odd_i));
                  brk_o   <= ~line & (sh == 8'h00) & ~nb;
                  state   <= serial_pkg::RX_IDLE;
               end
            end
            default: state <= serial_pkg::RX_IDLE;
         endcase
      end
   end
endmodule : char_rx
`default_nettype wire

// ==== src/serial_dev.sv ====
`timescale 1ns/10ps
`default_nettype none
// Function
// - eight data bits, least significant first
// - one low start bit opens character
// - one or two high stop bits
// - optional even/odd parity, checked on receive
// - independent directions, shared rate and format
// - one 16-bit baud divider for both
// - holding-empty flag one when writable
// - holding byte moves to shifter automatically
// - transmit request while enabled and empty
// - address flag bit sent as ninth
// - parity ignored while multidrop mode on
// - flow gate bit enables clear-to-send
// - separate enables; nothing sent unless tx_on
// - separate transmit and receive requests
// - framing, parity, overrun, break detected
// - nine-bit mode only while selected
// - driver enable high while transmitting
// - clear-to-send sampled clock before start
// - started character always finishes
// - address flag between data and stop
module serial_dev (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             tx_irq_o,
   output logic             rx_irq_o,
   serial_link_if.device    link
);
   logic [7:0]  ctrl;
   logic [15:0] baud, baud_cnt;
   logic        tick;
   logic [7:0]  hold, shreg, rx_buf;
   logic        hold_flag, tx_holding_empty, ninth_val, txd, de;
   logic        rx_avail, rx_ninth, perr, ferr, ovr, brk;
   logic        c1, c2, c3, cts_clear;
   logic [3:0]  tcnt;
   logic [2:0]  tidx;
   serial_pkg::tx_state_t state;
   logic        r_done, r_ninth, r_perr, r_ferr, r_brk;
   logic [7:0]  r_data;

   // ***************************************************
   // apb decode
   // ***************************************************
   wire setup   = psel_i & ~penable_i;
   wire fin     = psel_i & penable_i & pready_o;
   wire wr      = fin & pwrite_i;
   wire rd      = fin & ~pwrite_i;
   wire a_ctrl  = paddr_i == serial_pkg::OFS_CTRL;
   wire a_stat  = paddr_i == serial_pkg::OFS_STAT;
   wire a_txd   = paddr_i == serial_pkg::OFS_TXD;
   wire a_rxd   = paddr_i == serial_pkg::OFS_RXD;
   wire a_baud  = paddr_i == serial_pkg::OFS_BAUD;
   wire hit     = a_ctrl | a_stat | a_txd | a_rxd | a_baud;
   wire wr_ctrl = wr & a_ctrl;
   wire wr_baud = wr & a_baud;
   wire wr_txd  = wr & a_txd;
   wire rd_rxd  = rd & a_rxd;
   wire [7:0] clr = (wr & a_stat) ? pwdata_i[7:0] : 8'h00;

   wire tx_on    = ctrl[serial_pkg::C_TX_ON];
   wire rx_on    = ctrl[serial_pkg::C_RX_ON];
   wire odd      = ctrl[serial_pkg::C_PARITY_ODD];
   wire stop2    = ctrl[serial_pkg::C_STOP2];
   wire flow_on  = ctrl[serial_pkg::C_FLOW_GATE];
   wire mdrop    = ctrl[serial_pkg::C_MULTIDROP];
   wire par_on   = ctrl[serial_pkg::C_PARITY_ON] & ~mdrop;
   wire ninth_en = mdrop | par_on;

   wire [7:0] stat = {rx_ninth, brk, ovr, ferr, perr, rx_avail,
                      state != serial_pkg::TX_IDLE, tx_holding_empty};
   wire [31:0] rd_word = a_ctrl ? {24'h000000, ctrl} :
                         a_stat ? {24'h000000, stat} :
                         a_rxd  ? {24'h000000, rx_buf} :
                         a_baud ? {16'h0000, baud} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
         ctrl      <= serial_pkg::CTRL_RESET;
         baud      <= serial_pkg::BAUD_RESET;
      end else begin
         pready_o  <= setup;
         pslverr_o <= setup & ~hit;
         if (setup) begin
            prdata_o <= rd_word;
         end
         if (wr_ctrl) begin
            ctrl <= pwdata_i[7:0];
         end
         if (wr_baud) begin
            baud <= pwdata_i[15:0];
         end
      end
   end

   // ***************************************************
   // shared baud divider, sixteen ticks per bit
   // ***************************************************
   // single divider
   wire baud_last = baud_cnt >= (baud - 16'h0001);
   always_ff @(posedge clk_i) begin
      if (rst_i || wr_baud) begin
         baud_cnt <= 16'h0000;
         tick     <= 1'b0;
      end else begin
         tick     <= baud_last;
         baud_cnt <= baud_last ? 16'h0000 : baud_cnt + 16'h0001;
      end
   end

   // ***************************************************
   // clear-to-send synchroniser
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c1        <= 1'b1;
         c2        <= 1'b1;
         c3        <= 1'b1;
         cts_clear <= 1'b0;
      end else begin
         c1 <= link.cts_n;
         c2 <= c1;
         c3 <= c2;
         if (c2 == c3) begin
            cts_clear <= ~c3;
         end
      end
   end

   // ***************************************************
   // holding register and transmit shifter
   // ***************************************************
   // start gate
   wire can_start = (state == serial_pkg::TX_IDLE) & tx_on & ~tx_holding_empty &
                    (~flow_on | cts_clear) & ~wr_txd;
   wire bit_end   = tick & (tcnt == serial_pkg::OVS_LAST);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold             <= 8'h00;
         hold_flag        <= 1'b0;
         tx_holding_empty <= 1'b1;
      end else if (wr_txd && tx_holding_empty) begin
         hold             <= pwdata_i[7:0];
         hold_flag        <= ctrl[serial_pkg::C_ADDR_FLAG];
         tx_holding_empty <= 1'b0;
      end else if (can_start) begin
         tx_holding_empty <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state     <= serial_pkg::TX_IDLE;
         txd       <= 1'b1;
         de        <= 1'b0;
         shreg     <= 8'h00;
         ninth_val <= 1'b0;
         tcnt      <= 4'h0;
         tidx      <= 3'h0;
      end else begin
         if (tick) begin
            tcnt <= tcnt + 4'h1;
         end
         case (state)
            serial_pkg::TX_IDLE: begin
               txd  <= 1'b1;
               tcnt <= 4'h0;
               if (can_start) begin
                  shreg     <= hold;
                  ninth_val <= mdrop ? hold_flag : serial_pkg::par_bit(hold, odd);
                  txd       <= 1'b0;
                  de        <= 1'b1;
                  state     <= serial_pkg::TX_START;
               end
            end
            serial_pkg::TX_START: begin
               if (bit_end) begin
                  txd   <= shreg[0];
                  tidx  <= 3'h0;
                  state <= serial_pkg::TX_DATA;
               end
            end
            serial_pkg::TX_DATA: begin
               if (bit_end) begin
                  tidx  <= tidx + 3'h1;
                  shreg <= {1'b0, shreg[7:1]};
                  txd   <= shreg[1];
                  if (tidx == serial_pkg::LAST_IDX) begin
                     txd   <= ninth_en ? ninth_val : 1'b1;
                     state <= ninth_en ? serial_pkg::TX_NINTH : serial_pkg::TX_STOP1;
                  end
               end
            end
            serial_pkg::TX_NINTH: begin
               if (bit_end) begin
                  txd   <= 1'b1;
                  state <= serial_pkg::TX_STOP1;
               end
            end
            serial_pkg::TX_STOP1: begin
               if (bit_end) begin
                  de    <= stop2;
                  state <= stop2 ? serial_pkg::TX_STOP2 : serial_pkg::TX_IDLE;
               end
            end
            serial_pkg::TX_STOP2: begin
               if (bit_end) begin
                  de    <= 1'b0;
                  state <= serial_pkg::TX_IDLE;
               end
            end
            default: state <= serial_pkg::TX_IDLE;
         endcase
      end
   end

   assign link.dev_txd = txd;
   assign link.dev_de  = de;

   // ***************************************************
   // receiver and status flags
   // ***************************************************
   char_rx u_rx (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .tick_i       (tick),
      .en_i         (rx_on),
      .rxd_i        (link.far_txd),
      .ninth_on_i   (ninth_en),
      .parity_chk_i (par_on),
      .odd_i        (odd),
      .done_o       (r_done),
      .data_o       (r_data),
      .ninth_o      (r_ninth),
      .perr_o       (r_perr),
      .ferr_o       (r_ferr),
      .brk_o        (r_brk)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_buf   <= 8'h00;
         rx_ninth <= 1'b0;
         rx_avail <= 1'b0;
         perr     <= 1'b0;
         ferr     <= 1'b0;
         ovr      <= 1'b0;
         brk      <= 1'b0;
         tx_irq_o <= 1'b0;
         rx_irq_o <= 1'b0;
      end else begin
         if (r_done) begin
            rx_buf   <= r_data;
            rx_ninth <= r_ninth;
         end
         rx_avail <= (rx_avail & ~rd_rxd) | r_done;
         perr <= (perr & ~clr[serial_pkg::S_PERR]) | (r_done & r_perr);
         ferr <= (ferr & ~clr[serial_pkg::S_FERR]) | (r_done & r_ferr);
         brk  <= (brk & ~clr[serial_pkg::S_BRK]) | (r_done & r_brk);
         ovr  <= (ovr & ~clr[serial_pkg::S_OVERRUN]) | (r_done & rx_avail & ~rd_rxd);
         tx_irq_o <= tx_on & tx_holding_empty;
         rx_irq_o <= rx_on & (rx_avail | perr | ferr | ovr | brk);
      end
   end
endmodule : serial_dev
`default_nettype wire

// ==== src/serial_far.sv ====
`timescale 1ns/10ps
`default_nettype none
module serial_far (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [15:0] divisor_i,
   input  wire logic        parity_on_i,
   input  wire logic        parity_odd_i,
   input  wire logic        stop2_i,
   input  wire logic        multidrop_on_i,
   input  wire logic        hold_off_i,
   input  wire logic        send_valid_i,
   input  wire logic [7:0]  send_data_i,
   input  wire logic        send_ninth_i,
   output logic             send_ready_o,
   output logic             recv_valid_o,
   output logic [7:0]       recv_data_o,
   output logic             recv_ninth_o,
   output logic             recv_perr_o,
   output logic             recv_ferr_o,
   serial_link_if.far       link
);
   logic [15:0] dcnt;
   logic        tick, txd, cts_n;
   logic [11:0] frame;
   logic [3:0]  left, tcnt;

   wire par_on   = parity_on_i & ~multidrop_on_i;
   wire ninth_en = multidrop_on_i | par_on;
   wire d_last   = dcnt >= (divisor_i - 16'h0001);
   wire accept   = send_valid_i & send_ready_o;
   wire bit_end  = tick & (tcnt == serial_pkg::OVS_LAST);
   // address flag or parity as ninth
   wire nb       = multidrop_on_i ? send_ninth_i
                                  : serial_pkg::par_bit(send_data_i, parity_odd_i);
   wire [11:0] load = ninth_en ? {2'b11, nb, send_data_i, 1'b0}
                               : {3'b111, send_data_i, 1'b0};
   wire [3:0]  nbits = 4'ha + {3'h0, ninth_en} + {3'h0, stop2_i};

   // ***************************************************
   // baud divider and clear-to-send
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dcnt  <= 16'h0000;
         tick  <= 1'b0;
         cts_n <= 1'b1;
      end else begin
         tick  <= d_last;
         dcnt  <= d_last ? 16'h0000 : dcnt + 16'h0001;
         cts_n <= hold_off_i;
      end
   end

   // ***************************************************
   // transmitter
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame        <= 12'hfff;
         left         <= 4'h0;
         tcnt         <= 4'h0;
         txd          <= 1'b1;
         send_ready_o <= 1'b0;
      end else if (accept) begin
         frame        <= {1'b1, load[11:1]};
         txd          <= load[0];
         left         <= nbits;
         tcnt         <= 4'h0;
         send_ready_o <= 1'b0;
      end else if (left == 4'h0) begin
         txd          <= 1'b1;
         send_ready_o <= 1'b1;
      end else begin
         if (tick) begin
            tcnt <= tcnt + 4'h1;
         end
         if (bit_end) begin
            txd   <= (left == 4'h1) ? 1'b1 : frame[0];
            frame <= {1'b1, frame[11:1]};
            left  <= left - 4'h1;
         end
      end
   end

   assign link.far_txd = txd;
   assign link.cts_n   = cts_n;

   // ***************************************************
   // receiver
   // ***************************************************
   char_rx u_rx (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .tick_i       (tick),
      .en_i         (1'b1),
      .rxd_i        (link.dev_txd),
      .ninth_on_i   (ninth_en),
      .parity_chk_i (par_on),
      .odd_i        (parity_odd_i),
      .done_o       (recv_valid_o),
      .data_o       (recv_data_o),
      .ninth_o      (recv_ninth_o),
      .perr_o       (recv_perr_o),
      .ferr_o       (recv_ferr_o),
      .brk_o        ()
   );
endmodule : serial_far
`default_nettype wire

// ==== verif/serial_link_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module serial_link_monitor (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic dev_txd,
   input  wire logic dev_de,
   input  wire logic far_txd,
   input  wire logic cts_n
);
   logic [8:0] len;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ***************************************************
   // frame length counter
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || !dev_de) begin
         len <= 9'h000;
      end else begin
         len <= len + 9'h001;
      end
   end

   sequence s_low8;
      !dev_txd[*8];
   endsequence
   sequence s_high8;
      dev_txd[*8];
   endsequence

   property p_idle_high;
      !dev_de |-> dev_txd;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("line not high while idle");
   property p_de_start;
      $rose(dev_de) |-> $fell(dev_txd);
   endproperty
   a_de_start: assert property (p_de_start)
      else $error("driver enable not tied to start");
   property p_start_low;
      $rose(dev_de) |-> s_low8;
   endproperty
   a_start_low: assert property (p_start_low)
      else $error("start bit too short");
   property p_bit_min;
      $rose(dev_txd) |-> s_high8;
   endproperty
   a_bit_min: assert property (p_bit_min)
      else $error("high bit too short");
   property p_frame_len;
      $fell(dev_de) |-> len inside {[9'd158:9'd193]};
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame length out of range");
   property p_stop_high;
      $fell(dev_de) |-> $past(dev_txd, 1) && $past(dev_txd, 8) && $past(dev_txd, 15);
   endproperty
   a_stop_high: assert property (p_stop_high)
      else $error("stop bit not high");
   property p_cts_finish;
      $rose(cts_n) && dev_de && len < 9'd100 |=> dev_de;
   endproperty
   a_cts_finish: assert property (p_cts_finish)
      else $error("character cut short");
   property p_far_start;
      $fell(far_txd) |-> !far_txd[*8];
   endproperty
   a_far_start: assert property (p_far_start)
      else $error("far start bit too short");
endmodule : serial_link_monitor
`default_nettype wire

// ==== verif/tb_async_serial_transmit_framing.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_async_serial_transmit_framing;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0;
   logic [7:0]  paddr = 8'h00, cfg = 8'h00, sd = 8'h00, rd, c, d;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, tx_irq, rx_irq, rerr, sv = 1'b0, sn = 1'b0;
   logic        srdy, rv, rn, rpe, rfe;
   int          err_count = 0, samples_checked = 0, rx_cnt = 0, seen = 0;
   logic [15:0] rows [7] = '{16'h03a5, 16'h073c, 16'h0f3d, 16'h1381,
                            16'h4f5a, 16'hc37e, 16'h1fff};

   serial_link_if serial_link_if_inst ();
   serial_dev serial_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_irq_o(tx_irq),
      .rx_irq_o(rx_irq), .link(serial_link_if_inst));
   serial_far serial_far_inst (.clk_i(clk_i), .rst_i(rst_i), .divisor_i(16'h0001),
      .parity_on_i(cfg[2]), .parity_odd_i(cfg[3]), .stop2_i(cfg[4]),
      .multidrop_on_i(cfg[6]), .hold_off_i(hold), .send_valid_i(sv), .send_data_i(sd),
      .send_ninth_i(sn), .send_ready_o(srdy), .recv_valid_o(rv), .recv_data_o(rd),
      .recv_ninth_o(rn), .recv_perr_o(rpe), .recv_ferr_o(rfe), .link(serial_link_if_inst));
   serial_link_monitor serial_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
      .dev_txd(serial_link_if_inst.dev_txd), .dev_de(serial_link_if_inst.dev_de),
      .far_txd(serial_link_if_inst.far_txd), .cts_n(serial_link_if_inst.cts_n));

   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) if (rv === 1'b1) rx_cnt <= rx_cnt + 1;

   // ***************************************************
   // tasks
   // ***************************************************
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge between transfers
      @(posedge clk_i);
   endtask : apb
   task automatic wait_rx();
      int n;
      n = 0;
      while (rx_cnt == seen && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      @(posedge clk_i);
      seen++;
      chk("far count", rx_cnt, seen);
   endtask : wait_rx
   function automatic logic exp9(input logic [7:0] cf, input logic [7:0] x);
      return cf[6] ? cf[7] : ((^x) ^ cf[3]);
   endfunction : exp9
   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      end_of_test();
   end

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 7; i++) begin
         c = rows[i][15:8];
         d = rows[i][7:0];
         cfg <= c;
         apb(1'b1, serial_pkg::OFS_CTRL, {24'h0, c});
         apb(1'b1, serial_pkg::OFS_TXD, {24'h0, d});
         wait_rx();
         chk("far data", rd, d);
         if (c[2] | c[6]) chk("far ninth", rn, exp9(c, d));
         chk("far perr", {rpe, rfe}, 2'b00);
         sv <= 1'b1;
         sd <= ~d;
         sn <= exp9(c, ~d);
         do @(posedge clk_i); while (srdy !== 1'b1);
         sv <= 1'b0;
         do apb(1'b0, serial_pkg::OFS_STAT, 32'h0); while (rdat[2] !== 1'b1);
         chk("rx irq", rx_irq, 1'b1);
         chk("dev perr", rdat[4:3], 2'b00);
         if (c[6]) chk("dev ninth", rdat[7], c[7]);
         apb(1'b0, serial_pkg::OFS_RXD, 32'h0);
         chk("dev data", rdat, {24'h0, ~d});
      end
      cfg <= 8'h00;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      apb(1'b0, serial_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", rdat, 32'h0);
      apb(1'b0, serial_pkg::OFS_BAUD, 32'h0);
      chk("baud reset", rdat, 32'h1);
      apb(1'b1, serial_pkg::OFS_BAUD, 32'h1234);
      apb(1'b0, serial_pkg::OFS_BAUD, 32'h0);
      chk("baud", rdat, 32'h1234);
      apb(1'b1, serial_pkg::OFS_BAUD, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", rerr, 1'b1);
      chk("unmapped data", rdat, 32'h0);
      apb(1'b1, serial_pkg::OFS_TXD, 32'h55);
      repeat (200) @(posedge clk_i);
      apb(1'b0, serial_pkg::OFS_STAT, 32'h0);
      chk("held full", {rx_cnt == seen, rdat[0], tx_irq}, 3'b100);
      apb(1'b1, serial_pkg::OFS_CTRL, 32'h21);
      wait_rx();
      chk("late send", {rd, tx_irq}, 9'h0ab);
      hold <= 1'b1;
      // let the hold-off pass the pin synchroniser first
      repeat (8) @(posedge clk_i);
      apb(1'b1, serial_pkg::OFS_TXD, 32'h11);
      repeat (250) @(posedge clk_i);
      chk("gated", rx_cnt, seen);
      hold <= 1'b0;
      wait_rx();
      apb(1'b1, serial_pkg::OFS_TXD, 32'h22);
      apb(1'b0, serial_pkg::OFS_STAT, 32'h0);
      chk("moved", rdat[0], 1'b1);
      apb(1'b1, serial_pkg::OFS_TXD, 32'h33);
      hold <= 1'b1;
      wait_rx();
      chk("finish", rd, 8'h22);
      repeat (250) @(posedge clk_i);
      chk("pause", rx_cnt, seen);
      apb(1'b1, serial_pkg::OFS_CTRL, 32'h01);
      wait_rx();
      chk("ungated", rd, 8'h33);
      end_of_test();
   end
endmodule : tb_async_serial_transmit_framing
`default_nettype wire
